// >>> hdl/level_result_switching_io.sv
// Top of the level result switching I/O block with an Avalon-MM slave.
// Assumes switching inputs, fault and card pins are asynchronous and that
// element flags come from measurement logic on the same clock.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "level_io_defs.svh"

module level_result_switching_io #(
  parameter logic [16:0] MS_CYCLES = 17'(`LVL_TICK_MS * `LVL_CLK_KHZ),
  parameter logic [19:0] TMO_TICKS =
    20'(`LVL_TMO_MIN * `LVL_SEC_PER_MIN * `LVL_MS_PER_SEC / `LVL_TICK_MS)
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [5:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic [1:0] sw_in_i,
  input wire logic beam_fault_i,
  input wire logic card_present_i,
  input wire logic [`LVL_ELEMS-1:0] elem_over_i,
  output logic [1:0] result_o,
  output logic laser_on_o,
  output logic laser_led_o,
  output logic ready_green_o,
  output logic ready_red_o,
  output logic card_save_o,
  output logic [15:0] level_mm_o,
  output logic [3:0] cols_o,
  output logic [3:0] rows_o
);
  import level_io_pkg::*;

  top_state_s q, d;
  logic [1:0] start_ev;
  logic [1:0] stop_ev;
  logic [1:0] enc_ev;
  logic [1:0] res_hold;
  logic ext_start;
  logic trig_start;
  logic trig_stop;
  logic fault_in;
  logic card_in;
  logic wr_take;
  logic rd_take;
  logic tmo_hit;
  logic [1:0] mode;
  logic [31:0] out_cfg [2];

  assign fault_in = q.sync2[2];
  assign card_in = q.sync2[3];
  assign mode = q.ctrl[`LVL_CTRL_MODE];
  assign wr_take = write_i && q.ack;
  assign rd_take = read_i && !q.ack;
  assign out_cfg[0] = q.out0;
  assign out_cfg[1] = q.out1;

  for (genvar i = 0; i < 2; i++) begin : g_in
    logic [1:0] func;
    logic rise;
    logic fall;
    assign func = q.incfg[2*i+1 -: 2];
    assign rise = q.sync2[i] && !q.prev[i];
    assign fall = !q.sync2[i] && q.prev[i];
    assign start_ev[i] = rise && (func == `LVL_IN_START || func == `LVL_IN_STARTSTOP);
    assign stop_ev[i] = (rise && func == `LVL_IN_STOP) ||
                        (fall && func == `LVL_IN_STARTSTOP);
    // The encoder must stay below 300 Hz, far slower than the synchroniser.
    assign enc_ev[i] = rise && func == `LVL_IN_ENCODER;

    level_result_output u_out (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .elem_over_i(elem_over_i),
      .cols_i(q.matrix[`LVL_MAT_COLS]),
      .rows_i(q.matrix[`LVL_MAT_ROWS]),
      .src_i(out_cfg[i][`LVL_OUT_SRC]),
      .under_i(out_cfg[i][`LVL_OUT_UNDER]),
      .act_low_i(out_cfg[i][`LVL_OUT_ACT_LOW]),
      .hold_mode_i(out_cfg[i][`LVL_OUT_HOLD]),
      .index_i(out_cfg[i][`LVL_OUT_INDEX]),
      .dwell_ms_i(out_cfg[i][`LVL_OUT_DWELL]),
      .upd_i(q.upd),
      .ext_trig_i(q.ext_start),
      .cmd_rel_i(q.cmd_rel),
      .ms_tick_i(q.ms_tick),
      .pin_o(result_o[i]),
      .hold_o(res_hold[i])
    );
  end

  assign ext_start = |start_ev;
  assign trig_start = ext_start || q.cmd_start;
  assign trig_stop = (|stop_ev) || q.cmd_stop;
  assign tmo_hit = q.ctrl[`LVL_CTRL_TMO_EN] && q.ms_tick && q.tmo_cnt >= TMO_TICKS - 20'h0_0001;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    logic [31:0] ctrl_w;
    ctrl_w = be_merge({24'h00_0000, q.ctrl}, writedata_i, byteenable_i);
    d = q;
    d.sync1 = {card_present_i, beam_fault_i, sw_in_i};
    d.sync2 = q.sync1;
    d.prev = q.sync2[1:0];
    d.cmd_start = 1'b0;
    d.cmd_stop = 1'b0;
    d.cmd_rel = 1'b0;
    d.card_save = 1'b0;
    d.upd = 1'b0;
    d.ext_start = ext_start;

    // Bus slave: one wait cycle, then the request completes.
    d.ack = (read_i || write_i) && !q.ack;
    if (rd_take) begin
      unique case (address_i)
        `LVL_OFS_CTRL: d.rdata = {24'h00_0000, q.ctrl[7:4] & 4'h0, q.ctrl[3:0]};
        `LVL_OFS_INCFG: d.rdata = {28'h000_0000, q.incfg};
        `LVL_OFS_MATRIX: d.rdata = q.matrix;
        `LVL_OFS_OUT0: d.rdata = q.out0;
        `LVL_OFS_OUT1: d.rdata = q.out1;
        `LVL_OFS_STATUS: d.rdata = {q.enc_cnt, 9'h000, card_in, result_o,
                                    q.st == ST_ACTIVE, q.st == ST_FAULT, q.ready_g, q.laser};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (wr_take) begin
      unique case (address_i)
        `LVL_OFS_CTRL: begin
          d.ctrl = {4'h0, ctrl_w[3:0]};
          d.cmd_start = ctrl_w[`LVL_CTRL_CMD_START];
          d.cmd_stop = ctrl_w[`LVL_CTRL_CMD_STOP];
          d.cmd_rel = ctrl_w[`LVL_CTRL_CMD_REL];
          d.card_save = ctrl_w[`LVL_CTRL_CARD_SAVE] && card_in;
        end
        `LVL_OFS_INCFG: d.incfg = 4'(be_merge({28'h000_0000, q.incfg}, writedata_i,
                                              byteenable_i));
        `LVL_OFS_MATRIX: d.matrix = be_merge(q.matrix, writedata_i, byteenable_i);
        `LVL_OFS_OUT0: d.out0 = be_merge(q.out0, writedata_i, byteenable_i);
        `LVL_OFS_OUT1: d.out1 = be_merge(q.out1, writedata_i, byteenable_i);
        default: ;
      endcase
    end

    // Millisecond tick shared by laser timeout, auto cycle and dwell timers.
    d.ms_tick = 1'b0;
    if (q.ms_cnt >= MS_CYCLES - 17'h0_0001) begin
      d.ms_cnt = 17'h0_0000;
      d.ms_tick = 1'b1;
    end else begin
      d.ms_cnt = q.ms_cnt + 17'h0_0001;
    end

    d.enc_cnt = q.enc_cnt + 16'(enc_ev[0]) + 16'(enc_ev[1]);

    unique case (q.st)
      ST_IDLE: begin
        d.laser = 1'b0;
        if (mode != `LVL_MODE_TRIG) begin
          d.st = ST_ACTIVE;
          d.laser = 1'b1;
          d.auto_cnt = 8'h00;
        end else if (trig_start) begin
          d.st = ST_ACTIVE;
          d.laser = 1'b1;
          d.tmo_cnt = 20'h0_0000;
        end
      end
      ST_ACTIVE: begin
        if (mode == `LVL_MODE_TRIG) begin
          if (trig_stop) begin
            d.st = ST_IDLE;
            d.laser = 1'b0;
            d.upd = 1'b1;
          end else if (tmo_hit) begin
            d.st = ST_TMO;
            d.laser = 1'b0;
          end else if (q.ms_tick) begin
            d.tmo_cnt = q.tmo_cnt + 20'h0_0001;
          end
        end else begin
          // No timeout here: the laser runs while the mode is not triggered.
          d.laser = 1'b1;
          d.tmo_cnt = 20'h0_0000;
          if (mode == `LVL_MODE_AUTO && q.ms_tick) begin
            if (q.auto_cnt >= `LVL_AUTO_MS - 8'h01) begin
              d.auto_cnt = 8'h00;
              d.upd = 1'b1;
            end else begin
              d.auto_cnt = q.auto_cnt + 8'h01;
            end
          end
        end
      end
      ST_TMO: begin
        d.laser = 1'b0;
        if (trig_stop || mode != `LVL_MODE_TRIG) begin
          d.st = ST_IDLE;
          // A stop that lands while leaving triggered mode must not report a result.
          d.upd = trig_stop && mode == `LVL_MODE_TRIG;
        end
      end
      ST_FAULT: begin
        d.laser = 1'b0;
      end
    endcase

    // Entering triggered mode ends a free or auto cycle, so the laser waits for a trigger.
    if (q.st == ST_ACTIVE && mode != `LVL_MODE_TRIG && wr_take &&
        address_i == `LVL_OFS_CTRL && ctrl_w[`LVL_CTRL_MODE] == `LVL_MODE_TRIG) begin
      d.st = ST_IDLE;
      d.laser = 1'b0;
      d.upd = 1'b0;
    end

    // A beam fault is sticky until reset and overrides every state.
    if (fault_in) begin
      d.st = ST_FAULT;
      d.laser = 1'b0;
      d.upd = 1'b0;
    end

    d.ready_r = (d.st == ST_FAULT);
    // The ready lamp also blinks off for the one cycle of a card save.
    d.ready_g = !d.ready_r && !d.ctrl[`LVL_CTRL_XFER] && !d.card_save;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.ctrl <= `LVL_RST_CTRL;
      q.incfg <= `LVL_RST_INCFG;
      q.matrix <= `LVL_RST_MATRIX;
      q.out0 <= `LVL_RST_OUT0;
      q.out1 <= `LVL_RST_OUT1;
    end else begin
      q <= d;
    end
  end

  assign readdata_o = q.rdata;
  assign waitrequest_o = !q.ack;
  assign laser_on_o = q.laser;
  assign laser_led_o = q.laser;
  assign ready_green_o = q.ready_g;
  assign ready_red_o = q.ready_r;
  assign card_save_o = q.card_save;
  assign level_mm_o = q.matrix[`LVL_MAT_LEVEL];
  assign cols_o = q.matrix[`LVL_MAT_COLS];
  assign rows_o = q.matrix[`LVL_MAT_ROWS];

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_trig_start;
    q.st == ST_IDLE && mode == `LVL_MODE_TRIG && trig_start && !fault_in;
  endsequence

  sequence s_trig_stop;
    q.st == ST_ACTIVE && mode == `LVL_MODE_TRIG && trig_stop && !fault_in;
  endsequence

  property p_laser_on;
    s_trig_start |=> laser_on_o && q.st == ST_ACTIVE;
  endproperty
  a_laser_on: assert property (p_laser_on) else $error("laser not on at trigger");

  property p_laser_off;
    s_trig_stop |=> !laser_on_o ##0 q.upd;
  endproperty
  a_laser_off: assert property (p_laser_off) else $error("laser not off at trigger end");

  property p_timeout;
    q.st == ST_ACTIVE && mode == `LVL_MODE_TRIG && !trig_stop && !fault_in && tmo_hit
      |=> !laser_on_o && q.st == ST_TMO;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not stop laser");

  property p_no_timeout_free;
    (mode != `LVL_MODE_TRIG && !fault_in)[*3] |-> laser_on_o;
  endproperty
  a_no_timeout_free: assert property (p_no_timeout_free) else $error("laser off in free mode");

  property p_fault;
    fault_in |=> !laser_on_o && !laser_led_o ##1 ready_red_o && !ready_green_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not handled");

  property p_fault_no_result;
    q.st == ST_FAULT |-> !q.upd;
  endproperty
  a_fault_no_result: assert property (p_fault_no_result) else $error("result after fault");

  property p_xfer_ready;
    q.ctrl[`LVL_CTRL_XFER] |-> !ready_green_o;
  endproperty
  a_xfer_ready: assert property (p_xfer_ready) else $error("ready lit during transfer");

  property p_upd_cause;
    $rose(q.upd) && mode == `LVL_MODE_TRIG |-> $past(trig_stop);
  endproperty
  a_upd_cause: assert property (p_upd_cause) else $error("result without trigger end");

  property p_free_no_result;
    mode == `LVL_MODE_FREE && $past(mode) == `LVL_MODE_FREE |-> !q.upd;
  endproperty
  a_free_no_result: assert property (p_free_no_result) else $error("result in free mode");

  property p_encoder;
    $onehot(enc_ev) |=> q.enc_cnt == $past(q.enc_cnt) + 16'h0001;
  endproperty
  a_encoder: assert property (p_encoder) else $error("encoder pulse not counted");

  property p_card;
    card_save_o |-> $past(card_in) && !ready_green_o;
  endproperty
  a_card: assert property (p_card) else $error("card save without card");
endmodule

// >>> hdl/level_io_defs.svh
// Constants shared by the level result switching I/O block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef LEVEL_IO_DEFS_SVH
`define LEVEL_IO_DEFS_SVH

// Register byte offsets on the Avalon-MM slave.
`define LVL_OFS_CTRL 6'h00
`define LVL_OFS_INCFG 6'h04
`define LVL_OFS_MATRIX 6'h08
`define LVL_OFS_OUT0 6'h0c
`define LVL_OFS_OUT1 6'h10
`define LVL_OFS_STATUS 6'h14

// Reset values.
`define LVL_RST_CTRL 8'h01
`define LVL_RST_INCFG 4'ha
`define LVL_RST_MATRIX 32'h0064_0011
`define LVL_RST_OUT0 32'h0064_0100
`define LVL_RST_OUT1 32'h0064_0100

// Control register fields.
`define LVL_CTRL_MODE 1:0
`define LVL_CTRL_TMO_EN 2
`define LVL_CTRL_XFER 3
`define LVL_CTRL_CMD_START 4
`define LVL_CTRL_CMD_STOP 5
`define LVL_CTRL_CMD_REL 6
`define LVL_CTRL_CARD_SAVE 7

// Matrix register fields.
`define LVL_MAT_COLS 3:0
`define LVL_MAT_ROWS 7:4
`define LVL_MAT_LEVEL 31:16

// Result output configuration fields.
`define LVL_OUT_SRC 1:0
`define LVL_OUT_UNDER 2
`define LVL_OUT_ACT_LOW 3
`define LVL_OUT_HOLD 5:4
`define LVL_OUT_INDEX 15:8
`define LVL_OUT_DWELL 31:16

// Trigger modes, input functions, area sources and hold modes.
`define LVL_MODE_TRIG 2'h0
`define LVL_MODE_AUTO 2'h1
`define LVL_MODE_FREE 2'h2
`define LVL_IN_START 2'h0
`define LVL_IN_STOP 2'h1
`define LVL_IN_STARTSTOP 2'h2
`define LVL_IN_ENCODER 2'h3
`define LVL_SRC_MATRIX 2'h0
`define LVL_SRC_ROW 2'h1
`define LVL_SRC_COL 2'h2
`define LVL_SRC_ELEM 2'h3
`define LVL_HOLD_TIMER 2'h0
`define LVL_HOLD_TRIG 2'h1
`define LVL_HOLD_CMD 2'h2
`define LVL_HOLD_PERM 2'h3

// Matrix geometry.
`define LVL_DIM 15
`define LVL_ELEMS 225

// Timing: clock rate, tick period, laser timeout and auto cycle length.
`define LVL_CLK_KHZ 125000
`define LVL_TICK_MS 1
`define LVL_TMO_MIN 10
`define LVL_SEC_PER_MIN 60
`define LVL_MS_PER_SEC 1000
`define LVL_AUTO_MS 8'h14

`endif

// >>> hdl/level_io_pkg.sv
// Types of the level result switching I/O block.
// Assumes the constants header is on the include path.
`include "level_io_defs.svh"

package level_io_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACTIVE = 4'b0010,
    ST_TMO = 4'b0100,
    ST_FAULT = 4'b1000
  } laser_st_e;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [1:0] prev;
    laser_st_e st;
    logic laser;
    logic ack;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [3:0] incfg;
    logic [31:0] matrix;
    logic [31:0] out0;
    logic [31:0] out1;
    logic cmd_start;
    logic cmd_stop;
    logic cmd_rel;
    logic card_save;
    logic [16:0] ms_cnt;
    logic ms_tick;
    logic [19:0] tmo_cnt;
    logic [7:0] auto_cnt;
    logic [15:0] enc_cnt;
    logic upd;
    logic ext_start;
    logic ready_g;
    logic ready_r;
  } top_state_s;

  typedef struct packed {
    logic hold;
    logic pin;
    logic [15:0] dwell_cnt;
  } out_state_s;

endpackage

// >>> hdl/level_result_output.sv
// One result switching output: area evaluation, hold and output level.
// Assumes element flags, configuration and pulses come from the same clock.
`timescale 1ns/100ps
`include "level_io_defs.svh"

module level_result_output (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [`LVL_ELEMS-1:0] elem_over_i,
  input wire logic [3:0] cols_i,
  input wire logic [3:0] rows_i,
  input wire logic [1:0] src_i,
  input wire logic under_i,
  input wire logic act_low_i,
  input wire logic [1:0] hold_mode_i,
  input wire logic [7:0] index_i,
  input wire logic [15:0] dwell_ms_i,
  input wire logic upd_i,
  input wire logic ext_trig_i,
  input wire logic cmd_rel_i,
  input wire logic ms_tick_i,
  output logic pin_o,
  output logic hold_o
);
  import level_io_pkg::*;

  out_state_s q, d;
  logic [`LVL_ELEMS-1:0] considered;
  logic [`LVL_ELEMS-1:0] ok;
  logic match;

  for (genvar e = 0; e < `LVL_ELEMS; e++) begin : g_elem
    localparam logic [3:0] ROW = 4'(e / `LVL_DIM);
    localparam logic [3:0] COL = 4'(e % `LVL_DIM);
    localparam logic [7:0] ROWN = 8'(e / `LVL_DIM + 1);
    localparam logic [7:0] COLN = 8'(e % `LVL_DIM + 1);
    localparam logic [7:0] NUM = 8'(e + 1);
    logic area;
    always_comb begin
      unique case (src_i)
        `LVL_SRC_MATRIX: area = 1'b1;
        `LVL_SRC_ROW: area = (index_i == ROWN);
        `LVL_SRC_COL: area = (index_i == COLN);
        `LVL_SRC_ELEM: area = (index_i == NUM);
      endcase
    end
    // Only elements inside the configured matrix take part.
    assign considered[e] = (ROW < rows_i) && (COL < cols_i) && area;
    assign ok[e] = ~considered[e] | (elem_over_i[e] ^ under_i);
  end

  // An empty area never reports a fulfilled condition.
  assign match = (&ok) & (|considered);

  always_comb begin
    d = q;
    if (upd_i) begin
      d.hold = match;
      d.dwell_cnt = 16'h0000;
    end else if (q.hold) begin
      unique case (hold_mode_i)
        `LVL_HOLD_TIMER: begin
          if (q.dwell_cnt >= dwell_ms_i) begin
            d.hold = 1'b0;
          end else if (ms_tick_i) begin
            d.dwell_cnt = q.dwell_cnt + 16'h0001;
          end
        end
        `LVL_HOLD_TRIG: d.hold = ~ext_trig_i;
        `LVL_HOLD_CMD: d.hold = ~cmd_rel_i;
        `LVL_HOLD_PERM: d.hold = 1'b1;
      endcase
    end
    d.pin = d.hold ? ~act_low_i : act_low_i;
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_o = q.pin;
  assign hold_o = q.hold;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_idle_level;
    !hold_o && $stable(act_low_i) && !$rose(act_low_i) |-> pin_o == act_low_i;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle output not inverse level");

  property p_no_spurious_hold;
    !upd_i && !hold_o |=> !hold_o;
  endproperty
  a_no_spurious_hold: assert property (p_no_spurious_hold) else $error("hold without update");

  property p_perm_hold;
    hold_o && !upd_i && hold_mode_i == `LVL_HOLD_PERM |=> hold_o;
  endproperty
  a_perm_hold: assert property (p_perm_hold) else $error("permanent hold released");

  property p_cmd_release;
    hold_o && !upd_i && cmd_rel_i && hold_mode_i == `LVL_HOLD_CMD |=> !hold_o ##0 pin_o == $past(act_low_i);
  endproperty
  a_cmd_release: assert property (p_cmd_release) else $error("command did not end hold");
endmodule

// >>> verification/trigger_encoder_model.sv
// Behavioural object trigger and single-channel encoder on the switching inputs.
// Assumes the bench calls its tasks; both lines idle low between uses.
`timescale 1ns/100ps

module trigger_encoder_model #(
  parameter int ENC_HALF = 8
) (
  input wire logic ref_clk_i,
  output logic obj_o,
  output logic enc_o
);
  // The real encoder is far slower; a scaled half period keeps the run short.
  initial begin
    obj_o = 1'b0;
    enc_o = 1'b0;
  end

  task automatic set_object(input logic v);
    @(posedge ref_clk_i);
    obj_o <= v;
  endtask

  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_i);
      enc_o <= 1'b1;
      repeat (ENC_HALF) @(posedge ref_clk_i);
      enc_o <= 1'b0;
      repeat (ENC_HALF) @(posedge ref_clk_i);
    end
  endtask
endmodule

// >>> verification/level_result_switching_io_tb.sv
// Self-checking bench: Avalon-MM register access plus trigger and encoder stimulus.
// Assumes a 1 ms tick of 10 cycles and a timeout of 5 ticks in the design.
`timescale 1ns/100ps

module level_result_switching_io_tb;
  logic ref_clk_i;
  logic nrst_i;
  logic [5:0] address_i;
  logic read_i;
  logic write_i;
  logic [3:0] byteenable_i;
  logic [31:0] writedata_i;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic obj;
  logic enc;
  logic beam_fault_i;
  logic card_present_i;
  logic [224:0] elem_over_i;
  logic [1:0] result_o;
  logic laser_on_o;
  logic laser_led_o;
  logic ready_green_o;
  logic ready_red_o;
  logic card_save_o;
  logic [15:0] level_mm_o;
  logic [3:0] cols_o;
  logic [3:0] rows_o;
  int mismatches;
  int compares;
  int cycles;
  int saves;

  level_result_switching_io #(
    .MS_CYCLES(17'ha),
    .TMO_TICKS(20'h5)
  ) i_dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .sw_in_i({enc, obj}),
    .beam_fault_i(beam_fault_i), .card_present_i(card_present_i),
    .elem_over_i(elem_over_i), .result_o(result_o), .laser_on_o(laser_on_o),
    .laser_led_o(laser_led_o), .ready_green_o(ready_green_o), .ready_red_o(ready_red_o),
    .card_save_o(card_save_o), .level_mm_o(level_mm_o), .cols_o(cols_o), .rows_o(rows_o)
  );

  trigger_encoder_model i_src (.ref_clk_i(ref_clk_i), .obj_o(obj), .enc_o(enc));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang anywhere ends here rather than stalling the run.
  always @(posedge ref_clk_i) begin
    cycles++;
    if (card_save_o === 1'b1) saves++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk_i);
    address_i <= a;
    writedata_i <= wd;
    write_i <= wr;
    read_i <= ~wr;
    // Only the bench cycle limit ends a wait that never completes.
    do begin
      @(posedge ref_clk_i);
    end while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e, input string what);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, e, what);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic pins(input logic [1:0] res, input logic las, input string what);
    check(32'(result_o), 32'(res), what);
    check(32'(laser_on_o), 32'(las), what);
    check(32'(laser_led_o), 32'(las), what);
  endtask

  initial begin
    logic [31:0] st;
    nrst_i = 1'b0;
    address_i = 6'h0;
    read_i = 1'b0;
    write_i = 1'b0;
    byteenable_i = 4'hf;
    writedata_i = 32'h0;
    beam_fault_i = 1'b0;
    card_present_i = 1'b0;
    elem_over_i = '0;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    saves = 0;
    idle(5);
    nrst_i <= 1'b1;
    rd_chk(6'h00, 32'h0000_0001, "ctrl");
    rd_chk(6'h04, 32'h0000_000a, "incfg");
    rd_chk(6'h08, 32'h0064_0011, "matrix");
    rd_chk(6'h0c, 32'h0064_0100, "out0");
    rd_chk(6'h10, 32'h0064_0100, "out1");
    check({level_mm_o, 8'h0, rows_o, cols_o}, 32'h0064_0011, "matrix pins");
    wr(6'h18, 32'hffff_ffff);
    rd_chk(6'h18, 32'h0, "unmapped");
    check(32'(laser_on_o), 32'h1, "auto laser");
    check(32'(ready_green_o), 32'h1, "ready");
    wr(6'h00, 32'h0000_0009);
    idle(3);
    check(32'(ready_green_o), 32'h0, "ready in transfer");
    wr(6'h00, 32'h0000_0001);
    idle(3);
    check(32'(ready_green_o), 32'h1, "ready after transfer");
    $display("test defaults done");
    elem_over_i <= 225'h1;
    idle(300);
    check(32'(result_o[0]), 32'h1, "auto result");
    elem_over_i <= '0;
    wr(6'h00, 32'h0000_0000);
    idle(1200);
    pins(2'b00, 1'b0, "trig idle");
    elem_over_i <= 225'h1;
    i_src.set_object(1'b1);
    idle(8);
    pins(2'b00, 1'b1, "object present");
    i_src.set_object(1'b0);
    idle(8);
    pins(2'b11, 1'b0, "object gone");
    idle(1100);
    check(32'(result_o), 32'h0, "dwell over");
    $display("test input trigger done");
    wr(6'h0c, 32'h0064_0120);
    wr(6'h10, 32'h0064_010c);
    wr(6'h00, 32'h0000_0010);
    idle(4);
    pins(2'b10, 1'b1, "command start");
    wr(6'h00, 32'h0000_0020);
    idle(1100);
    pins(2'b11, 1'b0, "command hold");
    wr(6'h00, 32'h0000_0040);
    idle(4);
    check(32'(result_o), 32'h2, "command release");
    $display("test command trigger done");
    wr(6'h00, 32'h0000_0014);
    idle(4);
    check(32'(laser_on_o), 32'h1, "timeout armed");
    idle(80);
    check(32'(laser_on_o), 32'h0, "timeout fired");
    wr(6'h00, 32'h0000_0026);
    idle(150);
    check(32'(laser_on_o), 32'h1, "free ignores timeout");
    $display("test laser timeout done");
    wr(6'h00, 32'h0000_0000);
    wr(6'h04, 32'h0000_000e);
    i_src.pulses(3);
    idle(4);
    bus(1'b0, 6'h14, 32'h0, st);
    check(32'(st[31:16]), 32'h3, "encoder count");
    $display("test encoder done");
    wr(6'h00, 32'h0000_0080);
    idle(4);
    check(32'(saves), 32'h0, "no card");
    card_present_i <= 1'b1;
    idle(4);
    wr(6'h00, 32'h0000_0080);
    idle(4);
    check(32'(saves), 32'h1, "card save");
    $display("test card done");
    wr(6'h00, 32'h0000_0001);
    beam_fault_i <= 1'b1;
    idle(300);
    check(32'(laser_on_o), 32'h0, "fault laser");
    check({ready_red_o, ready_green_o}, 2'b10, "fault ready");
    check(32'(result_o), 32'h2, "fault results frozen");
    $display("test fault done");
    wrap_up();
  end
endmodule
